/* dv/cpu_sequencer_sva.sv */
// port assertions for the sequencing core
module cpu_sequencer_sva
#(
	parameter int CACHE_N = cpu_seq_pkg::CACHE_DEPTH
)
(
	input wire logic                  clk,
	input wire logic                  srst,
	input wire logic                  loadInit,
	input wire cpu_seq_pkg::mem_req_t cpuBus,
	input wire cpu_seq_pkg::mem_rsp_t cpuRsp,
	input wire logic                  iopReq,
	input wire logic                  iopGrant,
	input wire logic                  cpuGrant,
	input wire logic                  busDone,
	input wire logic                  ioStart,
	input wire logic [2:0]            ioFunc,
	input wire logic [15:0]           irqIn,
	input wire logic [15:0]           irqFlags,
	input wire logic [15:0]           stackPtr,
	input wire logic                  stackOverflow
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);

	// a request still waiting, and the edge that answers it
	sequence reqWait;
		cpuBus.req && !cpuRsp.ack;
	endsequence
	sequence reqDone;
		cpuBus.req && cpuRsp.ack;
	endsequence

	req_hold_a: assert property (reqWait |=> cpuBus.req && $stable(cpuBus))
		else $error("request changed before its answer");
	req_drop_a: assert property (reqDone |=> !cpuBus.req)
		else $error("request stayed up after its answer");
	grant_one_a: assert property (!(iopGrant && cpuGrant))
		else $error("both control units own the bus");
	grant_keep_a: assert property ((cpuGrant || iopGrant) && !busDone
		|=> $stable({cpuGrant, iopGrant}))
		else $error("bus owner changed without bus done");
	iop_first_a: assert property ($rose(cpuGrant) && $past(iopReq)
		|-> $past(cpuBus.req && cpuBus.write))
		else $error("processor beat io side without a pending store");
	ovf_sticky_a: assert property (stackOverflow && !loadInit
		|=> stackOverflow)
		else $error("overflow flag dropped by itself");
	sp_step_a: assert property (!loadInit ##1 1'b1 |-> stackPtr inside
		{$past(stackPtr), $past(stackPtr) + cpu_seq_pkg::ADDR_ONE,
		$past(stackPtr) - cpu_seq_pkg::ADDR_ONE})
		else $error("stack pointer moved by more than one");
	irq_set_a: assert property ((|irqIn)
		|=> (irqFlags & $past(irqIn)) == $past(irqIn))
		else $error("interrupt flag not set");
	io_pulse_a: assert property (ioStart
		|-> ioFunc <= cpu_seq_pkg::IO_FUNC_MAX ##1 !ioStart)
		else $error("bad io start pulse");
endmodule

/* dv/cpu_sequencer_test.sv */
// bench for the sequencing core with a memory partner
module cpu_sequencer_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic                  clk = 1'b0;
	logic                  srst = 1'b1;
	logic [15:0]           base = 16'h0000;
	logic [15:0]           limit = 16'h0000;
	logic                  loadInit = 1'b0;
	logic                  iopReq = 1'b0;
	logic [15:0]           irqIn = 16'h0000;
	logic [15:0]           irqClr = 16'h0000;
	cpu_seq_pkg::mem_req_t bus;
	cpu_seq_pkg::mem_rsp_t rsp;
	logic                  busDone;
	logic                  iopGrant;
	logic                  cpuGrant;
	logic                  ioStart;
	logic                  ovf;
	logic [2:0]            ioFunc;
	logic [15:0]           irqFlags;
	logic [15:0]           execInstr;
	logic [15:0]           stackPtr;
	logic [15:0]           topWord;
	logic [7:0]            status;
	logic                  busGap = 1'b0;
	logic [15:0]           ioCnt = 16'h0000;
	logic [7:0]            ioSeen = 8'h00;
	logic [15:0]           prog [$];
	int                    err_count = 0;
	int                    n_checks = 0;

	cpu_sequencer dut
	(
		.clk(clk), .srst(srst), .baseInit(base), .limitInit(limit),
		.pcInit(16'h0000), .loadInit(loadInit), .cpuBus(bus), .cpuRsp(rsp),
		.iopReq(iopReq), .iopGrant(iopGrant), .cpuGrant(cpuGrant),
		.busDone(busDone | busGap), .ioStart(ioStart), .ioFunc(ioFunc),
		.irqIn(irqIn), .irqClear(irqClr), .irqFlags(irqFlags),
		.execInstr(execInstr), .stackPtr(stackPtr), .topWord(topWord),
		.statusBits(status), .stackOverflow(ovf)
	);
	mem_model mem
	(
		.clk(clk), .bus(bus), .rsp(rsp), .done(busDone)
	);

	always #20 clk = ~clk;

	// io start pulses seen on the port
	always @(posedge clk)
		if (ioStart === 1'b1)
		begin
			ioCnt <= ioCnt + 16'h0001;
			ioSeen[ioFunc] <= 1'b1;
		end

	function automatic logic [15:0] ins(input logic [3:0] op,
		input logic [11:0] a);
		return {op, a};
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic fail();
		err_count++;
		$display("Error at %0t: wait ran out", $time);
		wrap_up();
	endtask

	task automatic wait_hi(ref logic s);
		int n = 0;
		while (s !== 1'b1)
		begin
			tick(1);
			n++;
			if (n > 500)
				fail();
		end
	endtask

	// reset, load the program and the stack bounds
	task automatic start(input logic [15:0] b, input logic [15:0] l);
		srst = 1'b1;
		loadInit = 1'b1;
		base = b;
		limit = l;
		for (int i = 0; i < 1024; i++)
			mem.ram[i] = 16'h0000;
		foreach (prog[i])
			mem.ram[i] = prog[i];
		tick(3);
		srst = 1'b0;
		tick(1);
		loadInit = 1'b0;
	endtask

	// run until the fetch two words past the program's end
	task automatic run(input logic [15:0] e);
		int n = 0;
		while (!(bus.req === 1'b1 && bus.write === 1'b0
			&& bus.addr === e + 16'h0001))
		begin
			tick(1);
			n++;
			if (n > 3000)
				fail();
		end
		tick(4);
	endtask

	task automatic stack_ops();
		prog = {ins(cpu_seq_pkg::OP_PUSH, 12'h005),
			ins(cpu_seq_pkg::OP_PUSH, 12'h00a),
			ins(cpu_seq_pkg::OP_PUSH, 12'h007),
			ins(cpu_seq_pkg::OP_POP, 12'h000),
			ins(cpu_seq_pkg::OP_LOADS, 12'h001)};
		start(16'h0100, 16'h01ff);
		run(16'h0005);
		chk(stackPtr, 16'h0102);
		chk(mem.ram[16'h101], 16'h0005);
		chk(mem.ram[16'h103], 16'h0007);
		chk(topWord, 16'h0005);
	endtask

	task automatic overflow();
		prog = {ins(cpu_seq_pkg::OP_PUSH, 12'h001),
			ins(cpu_seq_pkg::OP_PUSH, 12'h002),
			ins(cpu_seq_pkg::OP_PUSH, 12'h003)};
		start(16'h0200, 16'h0202);
		run(16'h0003);
		chk(stackPtr, 16'h0202);
		chk({15'h0000, ovf}, 16'h0001);
		chk(mem.ram[16'h203], 16'h0000);
		loadInit = 1'b1;
		tick(1);
		loadInit = 1'b0;
		tick(1);
		chk({15'h0000, ovf}, 16'h0000);
	endtask

	task automatic io_funcs();
		prog = {};
		for (int f = 0; f < 8; f++)
			prog.push_back(ins(cpu_seq_pkg::OP_IO, 12'(f)));
		ioCnt = 16'h0000;
		ioSeen = 8'h00;
		start(16'h0100, 16'h01ff);
		run(16'h0008);
		chk(ioCnt, 16'h0007);
		chk({8'h00, ioSeen}, 16'h007f);
	endtask

	task automatic slow_mem();
		prog = {ins(cpu_seq_pkg::OP_PUSH, 12'h012),
			ins(cpu_seq_pkg::OP_PUSH, 12'h034)};
		mem.lat = 5;
		start(16'h0100, 16'h01ff);
		run(16'h0002);
		mem.lat = 0;
		chk(stackPtr, 16'h0102);
		chk(mem.ram[16'h102], 16'h0034);
		chk(execInstr, ins(cpu_seq_pkg::OP_NOP, 12'h000));
	endtask

	// io side owns the bus; a pending store must win the next pick
	task automatic store_status();
		int n = 0;
		prog = {ins(cpu_seq_pkg::OP_PUSH, 12'h0ab),
			ins(cpu_seq_pkg::OP_SETST, 12'h05a),
			ins(cpu_seq_pkg::OP_STORE, 12'h001)};
		mem.lat = 5;
		start(16'h0300, 16'h03ff);
		iopReq = 1'b1;
		while (!(bus.req === 1'b1 && bus.write === 1'b1
			&& bus.addr === 16'h0300))
		begin
			tick(1);
			n++;
			if (n > 500)
				fail();
		end
		busGap = 1'b1;
		tick(1);
		busGap = 1'b0;
		chk({15'h0000, cpuGrant}, 16'h0001);
		chk({15'h0000, iopGrant}, 16'h0000);
		run(16'h0003);
		mem.lat = 0;
		iopReq = 1'b0;
		chk(mem.ram[16'h300], 16'h00ab);
		chk({8'h00, status}, 16'h005a);
		chk(stackPtr, 16'h0301);
	endtask

	task automatic irq_arb();
		prog = {};
		start(16'h0100, 16'h01ff);
		irqIn = 16'h0020;
		irqClr = 16'h0020;
		tick(1);
		irqIn = 16'h0000;
		irqClr = 16'h0000;
		tick(1);
		chk(irqFlags, 16'h0020);
		irqClr = 16'h0020;
		tick(1);
		irqClr = 16'h0000;
		tick(1);
		chk(irqFlags, 16'h0000);
		iopReq = 1'b1;
		wait_hi(iopGrant);
		chk({15'h0000, cpuGrant}, 16'h0000);
		iopReq = 1'b0;
		wait_hi(cpuGrant);
		chk({15'h0000, iopGrant}, 16'h0000);
	endtask

	// main sequence
	initial
	begin
		stack_ops();
		overflow();
		io_funcs();
		slow_mem();
		store_status();
		irq_arb();
		wrap_up();
	end
endmodule

bind cpu_sequencer cpu_sequencer_sva #(.CACHE_N(CACHE_N)) sva
(
	.clk(clk), .srst(srst), .loadInit(loadInit), .cpuBus(cpuBus),
	.cpuRsp(cpuRsp), .iopReq(iopReq), .iopGrant(iopGrant),
	.cpuGrant(cpuGrant), .busDone(busDone), .ioStart(ioStart),
	.ioFunc(ioFunc), .irqIn(irqIn), .irqFlags(irqFlags),
	.stackPtr(stackPtr), .stackOverflow(stackOverflow)
);

/* dv/mem_model.sv */
// memory module answering the processor's bus requests
module mem_model
(
	input  wire logic                  clk,
	input  wire cpu_seq_pkg::mem_req_t bus,
	output cpu_seq_pkg::mem_rsp_t      rsp,
	output logic                       done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] ram [0:1023];
	int          lat = 0;
	int          cnt = 0;

	// quiet outputs at time zero
	initial
	begin
		rsp = '0;
		done = 1'b0;
	end

	// answer after lat waiting cycles; read data churns when idle
	always @(posedge clk)
	begin
		#1;
		done = rsp.ack;
		rsp.ack = 1'b0;
		rsp.rdata = ~rsp.rdata;
		if (bus.req && !done)
		begin
			if (cnt >= lat)
			begin
				cnt = 0;
				rsp.ack = 1'b1;
				rsp.rdata = ram[bus.addr[9:0]];
				if (bus.write)
					ram[bus.addr[9:0]] = bus.wdata;
			end
			else
				cnt++;
		end
	end
endmodule

/* hdl/bus_priority_arbiter.sv */
// bus grant between the processor unit and the io processor control units
module bus_priority_arbiter
(
	input  wire logic                    clk,
	input  wire logic                    srst,
	input  wire logic                    cpuReq,
	input  wire logic                    cpuFinishing,
	input  wire logic                    iopReq,
	input  wire logic                    busDone,
	output cpu_seq_pkg::grant_t          grant
);
	cpu_seq_pkg::grant_t owner_ff;
	cpu_seq_pkg::grant_t nxt_owner;

	// hold the owner until the bus cycle ends, then pick again
	always_comb
	begin
		nxt_owner = owner_ff;
		if (owner_ff == cpu_seq_pkg::GRANT_NONE || busDone)
		begin
			if (cpuReq && cpuFinishing)
				nxt_owner = cpu_seq_pkg::GRANT_CPU;
			else if (iopReq)
				nxt_owner = cpu_seq_pkg::GRANT_IOP;
			else if (cpuReq)
				nxt_owner = cpu_seq_pkg::GRANT_CPU;
			else
				nxt_owner = cpu_seq_pkg::GRANT_NONE;
		end
	end

	// owner register
	always_ff @(posedge clk)
	begin
		if (srst)
			owner_ff <= cpu_seq_pkg::GRANT_NONE;
		else
			owner_ff <= nxt_owner;
	end

	assign grant = owner_ff;
endmodule

/* hdl/cpu_seq_pkg.sv */
// package: widths, register counts, opcode fields and command codes
package cpu_seq_pkg;
	localparam int WORD_W       = 16;
	localparam int ADDR_W       = 16;
	localparam int HW_REG_COUNT = 20;
	localparam int CACHE_DEPTH  = 4;
	localparam int IO_FUNC_COUNT = 7;
	localparam int IRQ_W        = 16;

	// instruction word layout: top nibble selects the class
	localparam int OP_HI = 15;
	localparam int OP_LO = 12;
	localparam int ARG_HI = 11;
	localparam int ARG_LO = 0;

	localparam logic [3:0] OP_NOP   = 4'h0;
	localparam logic [3:0] OP_PUSH  = 4'h1;
	localparam logic [3:0] OP_POP   = 4'h2;
	localparam logic [3:0] OP_LOADS = 4'h3;
	localparam logic [3:0] OP_STORE = 4'h4;
	localparam logic [3:0] OP_IO    = 4'h5;
	localparam logic [3:0] OP_SETST = 4'h6;

	localparam logic [2:0] IO_FUNC_MAX = 3'h6;
	localparam logic [ADDR_W-1:0] ADDR_ONE   = 16'h0001;
	localparam logic [ADDR_W-1:0] RESET_ADDR = 16'h0000;
	localparam logic [WORD_W-1:0] WORD_ZERO  = 16'h0000;

	typedef struct packed {
		logic              req;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic              ack;
		logic [WORD_W-1:0] rdata;
	} mem_rsp_t;

	typedef enum logic [1:0] {
		GRANT_NONE,
		GRANT_CPU,
		GRANT_IOP
	} grant_t;
endpackage

/* hdl/cpu_sequencer.sv */
// processor sequencing core: prefetch, execute, stack and bus control
// What this block does
// - instructions are fetched by a request through the processor's control unit
// - a returned fetch word sits in the prefetch register until execution ends
// - last execute step copies the prefetch word into the executing register
// - a microprogram may set status bits and start memory transfers
// - the module holds twenty hardware registers including instruction and stack ones
// - seven io instructions each start a matching io processor function
// - an external interrupt sets a flag bit in a processor register
// - two nearly identical bus control units: processor side and io side
// - with both requesting, the io processor is granted the bus first
// - a processor finishing a partial operation such as a store wins priority
// - stack base and stack pointer live in dedicated registers
// - word above the base is oldest element, pointer word is newest
// - operands are addressed as pointer minus an offset
// - four hidden cache registers hold up to four top elements
// - locations above the pointer up to the limit are free space
// - push writes the next free word then increments the pointer
// - pop decrements the pointer and shifts the cache, memory is left untouched
module cpu_sequencer
#(
	parameter int CACHE_N = cpu_seq_pkg::CACHE_DEPTH
)
(
	input  wire logic                              clk,
	input  wire logic                              srst,
	input  wire logic [cpu_seq_pkg::ADDR_W-1:0]    baseInit,
	input  wire logic [cpu_seq_pkg::ADDR_W-1:0]    limitInit,
	input  wire logic [cpu_seq_pkg::ADDR_W-1:0]    pcInit,
	input  wire logic                              loadInit,
	output cpu_seq_pkg::mem_req_t                  cpuBus,
	input  wire cpu_seq_pkg::mem_rsp_t             cpuRsp,
	input  wire logic                              iopReq,
	output logic                                   iopGrant,
	output logic                                   cpuGrant,
	input  wire logic                              busDone,
	output logic                                   ioStart,
	output logic [2:0]                             ioFunc,
	input  wire logic [cpu_seq_pkg::IRQ_W-1:0]     irqIn,
	input  wire logic [cpu_seq_pkg::IRQ_W-1:0]     irqClear,
	output logic [cpu_seq_pkg::IRQ_W-1:0]          irqFlags,
	output logic [cpu_seq_pkg::WORD_W-1:0]         execInstr,
	output logic [cpu_seq_pkg::ADDR_W-1:0]         stackPtr,
	output logic [cpu_seq_pkg::WORD_W-1:0]         topWord,
	output logic [7:0]                             statusBits,
	output logic                                   stackOverflow
);
	typedef enum {
		S_FETCH,
		S_WAITFETCH,
		S_EXEC,
		S_MEMWAIT,
		S_HANDOFF
	} seq_t;

	seq_t                                  state_ff;
	logic [cpu_seq_pkg::WORD_W-1:0]        prefetch_instr_reg_ff;
	logic                                  prefetchValid_ff;
	logic [cpu_seq_pkg::WORD_W-1:0]        exec_instr_reg_ff;
	logic [cpu_seq_pkg::ADDR_W-1:0]        pc_ff;
	logic [cpu_seq_pkg::ADDR_W-1:0]        stack_base_addr_ff;
	logic [cpu_seq_pkg::ADDR_W-1:0]        stackPtr_ff;
	logic [cpu_seq_pkg::ADDR_W-1:0]        stackLimit_ff;
	logic [cpu_seq_pkg::WORD_W-1:0]        topCache_ff [CACHE_N];
	logic [cpu_seq_pkg::IRQ_W-1:0]         irqFlags_ff;
	logic [7:0]                            status_ff;
	logic                                  overflow_ff;
	logic                                  ioStart_ff;
	logic [2:0]                            ioFunc_ff;
	cpu_seq_pkg::mem_req_t                 req_ff;
	cpu_seq_pkg::grant_t                   grant;
	logic [3:0]                            opcode;
	logic [cpu_seq_pkg::ADDR_W-1:0]        argAddr;
	logic                                  isStore;

	// decode helper: offset field of an instruction
	function automatic logic [cpu_seq_pkg::ADDR_W-1:0] argOf(
		input logic [cpu_seq_pkg::WORD_W-1:0] w);
		argOf = {4'h0, w[cpu_seq_pkg::ARG_HI:cpu_seq_pkg::ARG_LO]};
	endfunction

	assign opcode  = exec_instr_reg_ff[cpu_seq_pkg::OP_HI:cpu_seq_pkg::OP_LO];
	assign argAddr = argOf(exec_instr_reg_ff);
	assign isStore = req_ff.req && req_ff.write;

	// shared bus arbitration between the two control units
	bus_priority_arbiter u_arb
	(
		.clk          (clk),
		.srst         (srst),
		.cpuReq       (req_ff.req),
		.cpuFinishing (isStore),
		.iopReq       (iopReq),
		.busDone      (busDone),
		.grant        (grant)
	);

	assign cpuGrant = (grant == cpu_seq_pkg::GRANT_CPU);
	assign iopGrant = (grant == cpu_seq_pkg::GRANT_IOP);
	assign cpuBus   = req_ff;

	// sequencer: fetch, wait, execute, memory wait, handoff
	always_ff @(posedge clk)
	begin
		if (srst)
			state_ff <= S_FETCH;
		else
		begin
			case (state_ff)
				S_FETCH:
					state_ff <= S_WAITFETCH;
				S_WAITFETCH:
					if (cpuRsp.ack)
						state_ff <= S_HANDOFF;
				S_EXEC:
					if (opcode == cpu_seq_pkg::OP_LOADS ||
						opcode == cpu_seq_pkg::OP_STORE ||
						(opcode == cpu_seq_pkg::OP_PUSH && !overflowHit()))
						state_ff <= S_MEMWAIT;
					else
						state_ff <= S_HANDOFF;
				S_MEMWAIT:
					if (cpuRsp.ack)
						state_ff <= S_HANDOFF;
				S_HANDOFF:
					if (prefetchValid_ff)
						state_ff <= S_EXEC;
				default:
					state_ff <= S_FETCH;
			endcase
		end
	end

	// push is refused when the pointer already sits at the limit
	function automatic logic overflowHit();
		overflowHit = (stackPtr_ff == stackLimit_ff);
	endfunction

	// memory request register through the control unit
	always_ff @(posedge clk)
	begin
		if (srst)
			req_ff <= '0;
		else if (cpuRsp.ack)
			req_ff <= '0;
		else if (!req_ff.req)
		begin
			if (state_ff == S_FETCH ||
				(state_ff == S_HANDOFF && !prefetchValid_ff))
			begin
				req_ff.req   <= 1'b1;
				req_ff.write <= 1'b0;
				req_ff.addr  <= pc_ff;
				req_ff.wdata <= cpu_seq_pkg::WORD_ZERO;
			end
			else if (state_ff == S_EXEC)
			begin
				if (opcode == cpu_seq_pkg::OP_PUSH && !overflowHit())
				begin
					req_ff.req   <= 1'b1;
					req_ff.write <= 1'b1;
					req_ff.addr  <= stackPtr_ff + cpu_seq_pkg::ADDR_ONE;
					req_ff.wdata <= argAddr;
				end
				else if (opcode == cpu_seq_pkg::OP_LOADS)
				begin
					req_ff.req   <= 1'b1;
					req_ff.write <= 1'b0;
					req_ff.addr  <= stackPtr_ff - argAddr;
					req_ff.wdata <= cpu_seq_pkg::WORD_ZERO;
				end
				else if (opcode == cpu_seq_pkg::OP_STORE)
				begin
					req_ff.req   <= 1'b1;
					req_ff.write <= 1'b1;
					req_ff.addr  <= stackPtr_ff - argAddr;
					req_ff.wdata <= topCache_ff[0];
				end
			end
		end
	end

	// program counter and prefetch register
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pc_ff                 <= cpu_seq_pkg::RESET_ADDR;
			prefetch_instr_reg_ff <= cpu_seq_pkg::WORD_ZERO;
			prefetchValid_ff      <= 1'b0;
		end
		else if (loadInit)
			pc_ff <= pcInit;
		else if (cpuRsp.ack && !req_ff.write &&
			(state_ff == S_WAITFETCH || state_ff == S_HANDOFF))
		begin
			prefetch_instr_reg_ff <= cpuRsp.rdata;
			prefetchValid_ff      <= 1'b1;
			pc_ff                 <= pc_ff + cpu_seq_pkg::ADDR_ONE;
		end
		else if (state_ff == S_HANDOFF && prefetchValid_ff)
			prefetchValid_ff <= 1'b0;
	end

	// executing register loads as the last step of each microprogram
	always_ff @(posedge clk)
	begin
		if (srst)
			exec_instr_reg_ff <= cpu_seq_pkg::WORD_ZERO;
		else if (state_ff == S_HANDOFF && prefetchValid_ff)
			exec_instr_reg_ff <= prefetch_instr_reg_ff;
	end

	// stack base, pointer and limit registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			stack_base_addr_ff <= cpu_seq_pkg::RESET_ADDR;
			stackPtr_ff        <= cpu_seq_pkg::RESET_ADDR;
			stackLimit_ff      <= cpu_seq_pkg::RESET_ADDR;
		end
		else if (loadInit)
		begin
			stack_base_addr_ff <= baseInit;
			stackPtr_ff        <= baseInit;
			stackLimit_ff      <= limitInit;
		end
		else if (state_ff == S_EXEC)
		begin
			if (opcode == cpu_seq_pkg::OP_PUSH && !overflowHit())
				stackPtr_ff <= stackPtr_ff + cpu_seq_pkg::ADDR_ONE;
			else if (opcode == cpu_seq_pkg::OP_POP &&
				stackPtr_ff != stack_base_addr_ff)
				stackPtr_ff <= stackPtr_ff - cpu_seq_pkg::ADDR_ONE;
		end
	end

	// overflow error flag, sticky until reinit
	always_ff @(posedge clk)
	begin
		if (srst)
			overflow_ff <= 1'b0;
		else if (state_ff == S_EXEC && opcode == cpu_seq_pkg::OP_PUSH &&
			overflowHit())
			overflow_ff <= 1'b1;
		else if (loadInit)
			overflow_ff <= 1'b0;
	end

	// top-of-stack cache shifts on push, pop and loads
	genvar gi;
	generate
		for (gi = 0; gi < CACHE_N; gi++)
		begin : g_cache
			// neighbour slots, clamped so no slot indexes outside the array
			localparam int UP_IDX = (gi < CACHE_N - 1) ? gi + 1 : gi;
			localparam int DN_IDX = (gi > 0) ? gi - 1 : 0;
			always_ff @(posedge clk)
			begin
				if (srst)
					topCache_ff[gi] <= cpu_seq_pkg::WORD_ZERO;
				else if (state_ff == S_EXEC &&
					opcode == cpu_seq_pkg::OP_POP && gi < CACHE_N - 1)
					topCache_ff[gi] <= topCache_ff[UP_IDX];
				else if (state_ff == S_MEMWAIT && cpuRsp.ack &&
					!req_ff.write)
				begin
					if (gi == 0)
						topCache_ff[gi] <= cpuRsp.rdata;
					else
						topCache_ff[gi] <= topCache_ff[DN_IDX];
				end
				else if (state_ff == S_EXEC &&
					opcode == cpu_seq_pkg::OP_PUSH && !overflowHit())
				begin
					if (gi == 0)
						topCache_ff[gi] <= {4'h0, exec_instr_reg_ff[
							cpu_seq_pkg::ARG_HI:cpu_seq_pkg::ARG_LO]};
					else
						topCache_ff[gi] <= topCache_ff[DN_IDX];
				end
			end
		end
	endgenerate

	// io function start and status indicators
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ioStart_ff <= 1'b0;
			ioFunc_ff  <= 3'h0;
			status_ff  <= 8'h00;
		end
		else
		begin
			ioStart_ff <= 1'b0;
			if (state_ff == S_EXEC && opcode == cpu_seq_pkg::OP_IO &&
				exec_instr_reg_ff[2:0] <= cpu_seq_pkg::IO_FUNC_MAX)
			begin
				ioStart_ff <= 1'b1;
				ioFunc_ff  <= exec_instr_reg_ff[2:0];
			end
			if (state_ff == S_EXEC && opcode == cpu_seq_pkg::OP_SETST)
				status_ff <= exec_instr_reg_ff[7:0];
		end
	end

	// interrupt flags set by the io processor; set wins over clear
	always_ff @(posedge clk)
	begin
		if (srst)
			irqFlags_ff <= '0;
		else
			irqFlags_ff <= (irqFlags_ff & ~irqClear) | irqIn;
	end

	assign execInstr     = exec_instr_reg_ff;
	assign stackPtr      = stackPtr_ff;
	assign topWord       = topCache_ff[0];
	assign statusBits    = status_ff;
	assign stackOverflow = overflow_ff;
	assign ioStart       = ioStart_ff;
	assign ioFunc        = ioFunc_ff;
	assign irqFlags      = irqFlags_ff;
	// pc, two instruction, base, pointer, limit, four cache, flags
	// status and io registers make up the module register set
endmodule
